//--- src/lpcs_cmd_decode.sv
`timescale 1ns/1ps
// command byte decode: register address or special function
module lpcs_cmd_decode import lpcs_pkg::*; (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       rst,
  // byte written by the serial interface
  input wire logic       cmd_wr,
  input wire logic [7:0] cmd_byte,
  // decoded command
  lpcs_cmd_if.dec        c
);
  logic       is_cmd;
  logic       is_sf;
  logic [4:0] code;
  logic       clr_prox_r;
  logic       clr_color_r;
  logic [4:0] addr_r;
  logic [1:0] type_r;

  // bytes without the flag are data, not commands
  assign is_cmd = cmd_wr && cmd_byte[CMD_FLAG_BIT];
  assign is_sf  = is_cmd && (cmd_byte[TYPE_HI:TYPE_LO] == TYPE_SPECIAL);
  assign code   = cmd_byte[ADDR_HI:ADDR_LO];

  // one-shot clears; reserved codes and no-action do nothing
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      clr_prox_r  <= 1'b0;
      clr_color_r <= 1'b0;
    end else begin
      clr_prox_r  <= is_sf && (code == SF_CLR_PROX || code == SF_CLR_BOTH);
      clr_color_r <= is_sf && (code == SF_CLR_COLOR || code == SF_CLR_BOTH);
    end
  end

  // address kept for later transfers; a special code leaves it alone
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      addr_r <= ADDR_RST;
      type_r <= TYPE_RST;
    end else if (is_cmd && !is_sf) begin
      addr_r <= code;
      type_r <= cmd_byte[TYPE_HI:TYPE_LO];
    end
  end

  assign c.clr_prox  = clr_prox_r;
  assign c.clr_color = clr_color_r;
  assign c.reg_addr  = addr_r;
  assign c.xfer_type = type_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_sf_both_map: assert property (cmd_wr && cmd_byte == 8'he7 |=> clr_prox_r && clr_color_r)
    else $error("both-clear code did not clear both");
  a_sf_none_quiet: assert property (cmd_wr && cmd_byte == 8'he0 |=> !clr_prox_r && !clr_color_r)
    else $error("no-action code produced a clear");
  a_clear_one_shot: assert property (clr_prox_r |-> $past(is_sf))
    else $error("proximity clear without a fresh command");
  a_addr_capture: assert property (is_cmd && !is_sf |=> addr_r == $past(code))
    else $error("register address not captured");
endmodule : lpcs_cmd_decode

//--- src/lpcs_cycle_sequencer.sv
`timescale 1ns/1ps
// measurement cycle sequencer with command decode and interrupt flags
module lpcs_cycle_sequencer import lpcs_pkg::*; #(
  parameter int FIXED_LEN = FIXED_CYC,
  parameter int UNIT_LEN  = UNIT_CYC
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // command byte from the serial interface
  input  wire logic        cmd_wr,
  input  wire logic [7:0]  cmd_byte,
  input  wire logic        bus_active,
  // enable bits
  input  wire logic        power_up_bit,
  input  wire logic        prox_measure_enable,
  input  wire logic        wait_enable,
  input  wire logic        color_adc_enable,
  input  wire logic        prox_int_enable,
  input  wire logic        color_int_enable,
  // timing settings
  input  wire logic [7:0]  led_pulse_count,
  input  wire logic [7:0]  prox_integration_time,
  input  wire logic [7:0]  color_integration_time,
  input  wire logic [7:0]  wait_duration_setting,
  input  wire logic        wait_extend_x12,
  // threshold results from the compare logic
  input  wire logic        prox_out_of_range,
  input  wire logic        color_out_of_range,
  // front end control
  output logic             osc_enable,
  output logic             led_pulse_gate,
  output logic             prox_adc_run,
  output logic             color_adc_run,
  output logic             prox_done,
  output logic             color_done,
  // status and interrupts
  output lpcs_state_t      seq_state,
  output logic [4:0]       reg_addr,
  output logic [1:0]       xfer_type,
  output logic             prox_int,
  output logic             color_int,
  output logic             int_n
);

  // ---------------------------------------------------------------
  // sub-blocks
  // ---------------------------------------------------------------
  lpcs_tmr_if tmr ();
  lpcs_cmd_if cmd ();

  lpcs_cmd_decode u_dec (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .cmd_wr   (cmd_wr),
    .cmd_byte (cmd_byte),
    .c        (cmd)
  );

  lpcs_phase_timer u_tmr (
    .sys_clk (sys_clk),
    .rst     (rst),
    .t       (tmr)
  );

  // ---------------------------------------------------------------
  // state and phase selection
  // ---------------------------------------------------------------
  lpcs_state_t st_r;
  lpcs_state_t st_nxt;
  lpcs_state_t from_start;
  lpcs_state_t after_prox;
  lpcs_state_t after_wait;
  logic        prox_end;
  logic        color_end;
  logic        prox_int_r;
  logic        color_int_r;
  logic        prox_done_r;
  logic        color_done_r;
  logic [8:0]  wait_base;
  logic [12:0] wait_steps;

  // disabled phases are skipped; none enabled parks in idle
  always_comb begin
    if (prox_measure_enable) begin
      from_start = ST_PROX_ACCUM;
    end else if (wait_enable) begin
      from_start = ST_WAIT;
    end else if (color_adc_enable) begin
      from_start = ST_COLOR_INIT;
    end else begin
      from_start = ST_IDLE;
    end
  end

  // successors once proximity or wait is over
  always_comb begin
    if (wait_enable) begin
      after_prox = ST_WAIT;
    end else if (color_adc_enable) begin
      after_prox = ST_COLOR_INIT;
    end else begin
      after_prox = from_start;
    end
    if (color_adc_enable) begin
      after_wait = ST_COLOR_INIT;
    end else begin
      after_wait = from_start;
    end
  end

  // phase changes only on timer done, except out of sleep and idle; power loss wins at once
  always_comb begin
    st_nxt = st_r;
    if (!power_up_bit) begin
      st_nxt = ST_SLEEP;
    end else begin
      case (st_r)
        ST_SLEEP: begin
          st_nxt = ST_WARMUP;
        end
        ST_WARMUP: begin
          if (tmr.done) st_nxt = from_start;
        end
        ST_IDLE: begin
          st_nxt = from_start;
        end
        ST_PROX_ACCUM: begin
          if (tmr.done) st_nxt = ST_PROX_WAIT;
        end
        ST_PROX_WAIT: begin
          if (tmr.done) st_nxt = ST_PROX_CONV;
        end
        ST_PROX_CONV: begin
          if (tmr.done) st_nxt = after_prox;
        end
        ST_WAIT: begin
          if (tmr.done) st_nxt = after_wait;
        end
        ST_COLOR_INIT: begin
          if (tmr.done) st_nxt = ST_COLOR_CONV;
        end
        ST_COLOR_CONV: begin
          if (tmr.done) st_nxt = from_start;
        end
        default: begin
          st_nxt = ST_SLEEP;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r <= ST_SLEEP;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // phase lengths
  // ---------------------------------------------------------------
  // settings count down from full scale, one unit minimum
  assign wait_base  = FULL_SCALE - {1'b0, wait_duration_setting};
  assign wait_steps = wait_extend_x12 ? 13'(wait_base) * 13'(LONG_MULT)
                                      : {4'h0, wait_base};

  // reload on every entry except into sleep or idle, and on a phase that repeats itself
  always_comb begin
    tmr.load     = power_up_bit && ((st_nxt != st_r) || tmr.done)
                   && (st_nxt != ST_IDLE);
    tmr.steps    = STEP_W'(1);
    tmr.prescale = PRE_W'(1);
    case (st_nxt)
      ST_WARMUP, ST_PROX_WAIT, ST_COLOR_INIT: begin
        tmr.steps = STEP_W'(FIXED_LEN);
      end
      ST_PROX_ACCUM: begin
        tmr.prescale = PRE_W'(PULSE_CYC);
        if (led_pulse_count != 8'h00) begin
          tmr.steps = STEP_W'(led_pulse_count);
        end
      end
      ST_PROX_CONV: begin
        tmr.prescale = PRE_W'(UNIT_LEN);
        tmr.steps    = STEP_W'(FULL_SCALE - {1'b0, prox_integration_time});
      end
      ST_WAIT: begin
        tmr.prescale = PRE_W'(UNIT_LEN);
        tmr.steps    = STEP_W'(wait_steps);
      end
      ST_COLOR_CONV: begin
        tmr.prescale = PRE_W'(UNIT_LEN);
        tmr.steps    = STEP_W'(FULL_SCALE - {1'b0, color_integration_time});
      end
      default: begin
        tmr.steps = STEP_W'(1);
      end
    endcase
  end

  // ---------------------------------------------------------------
  // interrupt flags
  // ---------------------------------------------------------------
  assign prox_end  = (st_r == ST_PROX_CONV) && tmr.done;
  assign color_end = (st_r == ST_COLOR_CONV) && tmr.done;

  // set at end of conversion; a set beats a clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prox_int_r <= 1'b0;
    end else if (prox_end && prox_int_enable && prox_out_of_range) begin
      prox_int_r <= 1'b1;
    end else if (cmd.clr_prox) begin
      prox_int_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      color_int_r <= 1'b0;
    end else if (color_end && color_int_enable && color_out_of_range) begin
      color_int_r <= 1'b1;
    end else if (cmd.clr_color) begin
      color_int_r <= 1'b0;
    end
  end

  // result strobes for the data registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prox_done_r  <= 1'b0;
      color_done_r <= 1'b0;
    end else begin
      prox_done_r  <= prox_end;
      color_done_r <= color_end;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // bus traffic keeps the oscillator alive even when powered down
  assign osc_enable     = power_up_bit || bus_active;
  assign led_pulse_gate = (st_r == ST_PROX_ACCUM);
  assign prox_adc_run   = (st_r == ST_PROX_CONV);
  assign color_adc_run  = (st_r == ST_COLOR_CONV);
  assign prox_done      = prox_done_r;
  assign color_done     = color_done_r;
  assign seq_state      = st_r;
  assign reg_addr       = cmd.reg_addr;
  assign xfer_type      = cmd.xfer_type;
  assign prox_int       = prox_int_r;
  assign color_int      = color_int_r;
  assign int_n          = !(prox_int_r || color_int_r);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_sleep_no_power: assert property (!power_up_bit |=> st_r == ST_SLEEP)
    else $error("sequencer not asleep with power bit clear");
  a_warmup_first: assert property (
      st_r == ST_SLEEP && power_up_bit |=> st_r == ST_WARMUP)
    else $error("power-up did not start warm-up");
  a_fixed_phase_len: assert property (
      tmr.load && (st_nxt == ST_WARMUP || st_nxt == ST_PROX_WAIT || st_nxt == ST_COLOR_INIT)
      |-> tmr.steps == STEP_W'(FIXED_LEN) && tmr.prescale == PRE_W'(1))
    else $error("fixed phase loaded with wrong length");
  a_prox_order: assert property (
      st_r == ST_PROX_ACCUM && power_up_bit && tmr.done
      |=> st_r == ST_PROX_WAIT)
    else $error("accumulate not followed by proximity wait");
  a_color_order: assert property (
      st_r == ST_COLOR_INIT && power_up_bit && tmr.done |=> st_r == ST_COLOR_CONV)
    else $error("color init not followed by conversion");
  a_wait_scale: assert property (
      tmr.load && st_nxt == ST_WAIT && wait_extend_x12
      |-> tmr.steps == STEP_W'(12 * (256 - int'(wait_duration_setting))))
    else $error("extended wait length wrong");
  a_prox_int_end: assert property (
      $rose(prox_int_r) |-> $past(st_r) == ST_PROX_CONV && $past(tmr.done))
    else $error("proximity interrupt outside conversion end");
  a_color_int_end: assert property (
      $rose(color_int_r) |-> $past(st_r) == ST_COLOR_CONV && $past(tmr.done))
    else $error("color interrupt outside conversion end");
  a_int_sticky: assert property (prox_int_r && !cmd.clr_prox |=> prox_int_r)
    else $error("proximity interrupt dropped without clear");
  a_int_cleared: assert property (cmd.clr_prox && !prox_end |=> !prox_int_r)
    else $error("proximity interrupt survived clear");
  a_color_sticky: assert property (color_int_r && !cmd.clr_color |=> color_int_r)
    else $error("color interrupt dropped without clear");
  a_color_cleared: assert property (cmd.clr_color && !color_end |=> !color_int_r)
    else $error("color interrupt survived clear");
  // lengths are fixed at entry; a setting written mid-phase waits for the next pass
  a_prox_conv_len: assert property (
      tmr.load && st_nxt == ST_PROX_CONV
      |-> tmr.steps == STEP_W'(256 - int'(prox_integration_time))
          && tmr.prescale == PRE_W'(UNIT_LEN))
    else $error("proximity conversion loaded with wrong length");
  a_color_conv_len: assert property (
      tmr.load && st_nxt == ST_COLOR_CONV
      |-> tmr.steps == STEP_W'(256 - int'(color_integration_time))
          && tmr.prescale == PRE_W'(UNIT_LEN))
    else $error("color conversion loaded with wrong length");

endmodule : lpcs_cycle_sequencer

//--- src/lpcs_ifs.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// phase timer request and done
// ---------------------------------------------------------------
interface lpcs_tmr_if import lpcs_pkg::*; ();
  logic              load;
  logic [STEP_W-1:0] steps;
  logic [PRE_W-1:0]  prescale;
  logic              done;
  modport seq (output load, steps, prescale, input done);
  modport tmr (input load, steps, prescale, output done);
endinterface : lpcs_tmr_if

// ---------------------------------------------------------------
// decoded command byte
// ---------------------------------------------------------------
interface lpcs_cmd_if;
  logic       clr_prox;
  logic       clr_color;
  logic [4:0] reg_addr;
  logic [1:0] xfer_type;
  modport dec (output clr_prox, clr_color, reg_addr, xfer_type);
  modport seq (input clr_prox, clr_color, reg_addr, xfer_type);
endinterface : lpcs_cmd_if

//--- src/lpcs_phase_timer.sv
`timescale 1ns/1ps
// phase timer: steps x prescale cycles from load to done
module lpcs_phase_timer import lpcs_pkg::*; (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // request from the sequencer
  lpcs_tmr_if.tmr  t
);
  logic [PRE_W-1:0]  len_r;
  logic [PRE_W-1:0]  pre_r;
  logic [STEP_W-1:0] left_r;
  logic              step;

  // divider gives a one-cycle step enable
  assign step   = (left_r != '0) && (pre_r == '0);
  assign t.done = step && (left_r == STEP_W'(1));

  // a load restarts the divider so the first step is full length
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      len_r  <= '0;
      pre_r  <= '0;
      left_r <= '0;
    end else if (t.load) begin
      len_r  <= t.prescale;
      pre_r  <= t.prescale - PRE_W'(1);
      left_r <= t.steps;
    end else if (step) begin
      pre_r  <= len_r - PRE_W'(1);
      left_r <= left_r - STEP_W'(1);
    end else if (left_r != '0) begin
      pre_r  <= pre_r - PRE_W'(1);
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_done_single_pulse: assert property (t.done && !t.load |=> !t.done)
    else $error("timer done longer than one cycle");
endmodule : lpcs_phase_timer

//--- src/lpcs_pkg.sv
package lpcs_pkg;

  // ---------------------------------------------------------------
  // command byte layout and codes
  // ---------------------------------------------------------------
  localparam int       CMD_FLAG_BIT = 7;
  localparam int       TYPE_HI      = 6;
  localparam int       TYPE_LO      = 5;
  localparam int       ADDR_HI      = 4;
  localparam int       ADDR_LO      = 0;
  localparam logic [1:0] TYPE_SPECIAL = 2'h3;
  localparam logic [1:0] TYPE_RST     = 2'h0;
  localparam logic [4:0] ADDR_RST     = 5'h00;
  localparam logic [4:0] SF_NONE      = 5'h00;
  localparam logic [4:0] SF_CLR_PROX  = 5'h05;
  localparam logic [4:0] SF_CLR_COLOR = 5'h06;
  localparam logic [4:0] SF_CLR_BOTH  = 5'h07;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam real CLK_PERIOD_NS = 5.0;
  localparam real FIXED_MS      = 2.4;
  localparam real UNIT_MS       = 2.38;
  localparam real PULSE_US      = 16.0;
  localparam int  FIXED_CYC     = int'(FIXED_MS * 1.0e6 / CLK_PERIOD_NS);
  localparam int  UNIT_CYC      = int'($floor(UNIT_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int  PULSE_CYC     = int'($floor(PULSE_US * 1.0e3 / CLK_PERIOD_NS));
  localparam int  STEP_W        = 20;
  localparam int  PRE_W         = 19;
  localparam logic [8:0] FULL_SCALE = 9'h100;
  localparam logic [3:0] LONG_MULT  = 4'hc;

  // ---------------------------------------------------------------
  // sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_SLEEP, ST_WARMUP, ST_IDLE, ST_PROX_ACCUM, ST_PROX_WAIT,
    ST_PROX_CONV, ST_WAIT, ST_COLOR_INIT, ST_COLOR_CONV
  } lpcs_state_t;

endpackage : lpcs_pkg

//--- tb/lpcs_host_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// serial host side of the command port
// ---------------------------------------------------------------
module lpcs_host_model (
  // clock
  input  wire logic  sys_clk,
  // command port
  output logic       cmd_wr,
  output logic [7:0] cmd_byte,
  output logic       bus_active
);
  // idle port at time zero
  initial begin
    cmd_wr     = 1'b0;
    cmd_byte   = 8'h00;
    bus_active = 1'b0;
  end

  // one byte: changed just after an edge, held over the taking edge
  task automatic send(input logic [7:0] b);
    // reserved special codes are never put on the bus
    if (b[6:5] == 2'h3 && !(b[4:0] inside {5'h00, 5'h05, 5'h06, 5'h07})) return;
    bus_active = 1'b1;
    cmd_wr     = 1'b1;
    cmd_byte   = b;
    @(posedge sys_clk);
    #1;
    cmd_wr     = 1'b0;
    cmd_byte   = ~b; // stale data must not look valid
    bus_active = 1'b0;
  endtask : send
endmodule : lpcs_host_model

//--- tb/tb.sv
`timescale 1ns/1ps
module tb import lpcs_pkg::*; ();
  localparam int FL = 20;
  localparam int UL = 10;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        sys_clk, rst, cmd_wr, bus_active, osc_enable;
  logic [7:0]  cmd_byte, led_pulse_count, prox_integration_time;
  logic [7:0]  color_integration_time, wait_duration_setting;
  logic        power_up_bit, prox_measure_enable, wait_enable, color_adc_enable;
  logic        prox_int_enable, color_int_enable, wait_extend_x12;
  logic        prox_out_of_range, color_out_of_range, led_pulse_gate;
  logic        prox_adc_run, color_adc_run, prox_done, color_done;
  logic        prox_int, color_int, int_n;
  logic [4:0]  reg_addr;
  logic [1:0]  xfer_type;
  lpcs_state_t seq_state;
  int          err_count, samples_checked, cyc;

  lpcs_host_model i_host (.sys_clk, .cmd_wr, .cmd_byte, .bus_active);
  lpcs_cycle_sequencer #(.FIXED_LEN(FL), .UNIT_LEN(UL)) i_dut (
    .sys_clk, .rst, .cmd_wr, .cmd_byte, .bus_active, .power_up_bit,
    .prox_measure_enable, .wait_enable, .color_adc_enable, .prox_int_enable,
    .color_int_enable, .led_pulse_count, .prox_integration_time,
    .color_integration_time, .wait_duration_setting, .wait_extend_x12,
    .prox_out_of_range, .color_out_of_range, .osc_enable, .led_pulse_gate,
    .prox_adc_run, .color_adc_run, .prox_done, .color_done, .seq_state,
    .reg_addr, .xfer_type, .prox_int, .color_int, .int_n);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // clock: 200 MHz
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // hang guard, well above the roughly 20000 cycles the run needs
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : step

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic chk_st(input lpcs_state_t e);
    chk("seq_state", 8'(e), 8'(seq_state));
  endtask : chk_st

  task automatic chk_n(input string nm, input int e, input int g);
    samples_checked++;
    if (g != e) begin
      err_count++;
      $display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chk_n

  // must be in s now; counts its cycles until it leaves
  task automatic phase(input lpcs_state_t s, input int len);
    int n;
    n = 0;
    chk_st(s);
    while (seq_state === s && n < 9000) begin
      step(1);
      n++;
    end
    chk_n("phase length", len, n);
  endtask : phase

  task automatic wait_st(input lpcs_state_t s);
    int n;
    n = 0;
    while (seq_state !== s && n < 9000) begin
      step(1);
      n++;
    end
  endtask : wait_st

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic s_reset();
    chk_st(ST_SLEEP);
    chk("reg_addr", 8'h00, 8'(reg_addr));
    chk("int_n", 8'h01, 8'(int_n));
    chk("osc_enable", 8'h00, 8'(osc_enable));
  endtask : s_reset

  task automatic s_addr();
    i_host.send(8'ha3);
    step(1);
    chk("reg_addr", 8'h03, 8'(reg_addr));
    chk("xfer_type", 8'h01, 8'(xfer_type));
    i_host.send(8'h3f); // data byte, not a command
    step(1);
    chk("reg_addr", 8'h03, 8'(reg_addr));
    i_host.send(8'he0);
    step(1);
    chk("xfer_type", 8'h01, 8'(xfer_type));
    // bus traffic alone must wake the oscillator while powered down
    fork
      i_host.send(8'h9f);
      begin
        #1;
        chk("osc_enable", 8'h01, 8'(osc_enable));
      end
    join
    step(1);
    chk("reg_addr", 8'h1f, 8'(reg_addr));
    chk("xfer_type", 8'h00, 8'(xfer_type));
  endtask : s_addr

  task automatic s_prox();
    prox_measure_enable = 1'b1;
    led_pulse_count     = 8'h02;
    power_up_bit        = 1'b1;
    step(1);
    phase(ST_WARMUP, FL);
    phase(ST_PROX_ACCUM, 2 * PULSE_CYC);
    phase(ST_PROX_WAIT, FL);
    chk("prox_int", 8'h00, 8'(prox_int));
    phase(ST_PROX_CONV, 2 * UL);
    chk("prox_int", 8'h01, 8'(prox_int));
    chk("prox_done", 8'h01, 8'(prox_done));
    chk_st(ST_PROX_ACCUM);
    i_host.send(8'he0);
    step(2);
    chk("prox_int", 8'h01, 8'(prox_int));
    chk("int_n", 8'h00, 8'(int_n));
    i_host.send(8'he5);
    step(2);
    chk("prox_int", 8'h00, 8'(prox_int));
    chk("int_n", 8'h01, 8'(int_n));
    wait_st(ST_PROX_CONV);
    phase(ST_PROX_CONV, 2 * UL);
    chk("prox_int", 8'h01, 8'(prox_int));
    power_up_bit = 1'b0;
    step(1);
    chk_st(ST_SLEEP);
    step(4);
    chk_st(ST_SLEEP);
  endtask : s_prox

  task automatic s_color();
    // proximity off while wait and color are on
    prox_measure_enable = 1'b0;
    wait_enable         = 1'b1;
    wait_extend_x12     = 1'b1;
    color_adc_enable    = 1'b1;
    power_up_bit        = 1'b1;
    step(1);
    phase(ST_WARMUP, FL);
    phase(ST_WAIT, 2 * 12 * UL);
    phase(ST_COLOR_INIT, FL);
    chk("color_int", 8'h00, 8'(color_int));
    phase(ST_COLOR_CONV, 3 * UL);
    chk("color_int", 8'h01, 8'(color_int));
    chk("color_done", 8'h01, 8'(color_done));
    chk_st(ST_WAIT);
    wait_extend_x12 = 1'b0; // takes effect at the next wait entry
    i_host.send(8'he6);
    step(2);
    chk("color_int", 8'h00, 8'(color_int));
    chk("prox_int", 8'h01, 8'(prox_int));
    i_host.send(8'he7);
    step(2);
    chk("prox_int", 8'h00, 8'(prox_int));
    wait_st(ST_COLOR_CONV);
    phase(ST_COLOR_CONV, 3 * UL);
    phase(ST_WAIT, 2 * UL);
  endtask : s_color

  // mid-run reset, then all phases with new settings and gated interrupts
  task automatic s_gate();
    rst                    = 1'b1;
    prox_measure_enable    = 1'b1;
    led_pulse_count        = 8'h00; // zero counts as one pulse
    prox_integration_time  = 8'hfd;
    color_integration_time = 8'hfe;
    wait_duration_setting  = 8'hfd;
    prox_int_enable        = 1'b0;
    color_out_of_range     = 1'b0;
    step(2);
    rst = 1'b0;
    chk("color_int", 8'h00, 8'(color_int));
    chk_st(ST_SLEEP);
    step(1);
    chk("osc_enable", 8'h01, 8'(osc_enable));
    phase(ST_WARMUP, FL);
    chk("led_pulse_gate", 8'h01, 8'(led_pulse_gate));
    phase(ST_PROX_ACCUM, PULSE_CYC);
    phase(ST_PROX_WAIT, FL);
    chk("prox_adc_run", 8'h01, 8'(prox_adc_run));
    phase(ST_PROX_CONV, 3 * UL);
    chk("prox_int", 8'h00, 8'(prox_int));
    chk("prox_done", 8'h01, 8'(prox_done));
    chk("prox_adc_run", 8'h00, 8'(prox_adc_run));
    phase(ST_WAIT, 3 * UL);
    phase(ST_COLOR_INIT, FL);
    chk("color_adc_run", 8'h01, 8'(color_adc_run));
    phase(ST_COLOR_CONV, 2 * UL);
    chk("color_int", 8'h00, 8'(color_int));
    chk("color_done", 8'h01, 8'(color_done));
    chk_st(ST_PROX_ACCUM);
    // all off: the running pass ends, then the sequencer parks in idle
    prox_measure_enable = 1'b0;
    wait_enable         = 1'b0;
    color_adc_enable    = 1'b0;
    wait_st(ST_IDLE);
    step(3);
    chk_st(ST_IDLE);
  endtask : s_gate

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst                    = 1'b1;
    power_up_bit           = 1'b0;
    prox_measure_enable    = 1'b0;
    wait_enable            = 1'b0;
    color_adc_enable       = 1'b0;
    prox_int_enable        = 1'b1;
    color_int_enable       = 1'b1;
    led_pulse_count        = 8'h01;
    prox_integration_time  = 8'hfe;
    color_integration_time = 8'hfd;
    wait_duration_setting  = 8'hfe;
    wait_extend_x12        = 1'b0;
    prox_out_of_range      = 1'b1;
    color_out_of_range     = 1'b1;
    step(8);
    rst = 1'b0;
    step(1);
    s_reset();
    s_addr();
    s_prox();
    s_color();
    s_gate();
    test_done();
  end
endmodule : tb
